// ==== logic/pdw_pkg.sv ====
package pdw_pkg;
   localparam int unsigned CLK_HZ = 200000000;
   localparam int unsigned SAMPLE_HZ = 50000;
   localparam int unsigned SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
   localparam int unsigned AREA_BITS = 2;
   localparam int unsigned AREA_LSB = 10;
   localparam int unsigned UPPER_LSB = 12;
   localparam int unsigned OFFSET_BITS = 10;
   localparam logic [1:0] AREA_RAM0 = 2'h0;
   localparam logic [1:0] AREA_RAM1 = 2'h1;
   localparam logic [1:0] AREA_FADE = 2'h2;
   localparam logic [1:0] AREA_PANEL = 2'h3;
   localparam int unsigned DRIVE_LINES = 7;
   localparam logic [2:0] WHEEL_INDEX = 3'h7;
   localparam logic signed [7:0] COUNT_LIMIT = 8'sh78;
endpackage

// ==== logic/pdw_step_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface pdw_step_if;
   logic up;
   logic down;
   modport src (output up, output down);
   modport dst (input up, input down);
endinterface
`default_nettype wire

// ==== logic/pdw_quad_decode.sv ====
`timescale 1ns/100ps
`default_nettype none
module pdw_quad_decode (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic sample_en_i,
   input wire logic phase1_i,
   input wire logic phase2_i,
   pdw_step_if.src step
);
   typedef struct packed {
      logic [1:0] sync1;
      logic [1:0] sync2;
      logic [1:0] first;
      logic [1:0] second;
      logic [2:0] fill;
   } pdw_qd_state_t;
   localparam logic [2:0] FILL_DONE = 3'h4;
   pdw_qd_state_t s_q;
   pdw_qd_state_t s_d;
   logic [3:0] idx;
   logic primed;
   logic [1:0] moved;

   always_comb
   begin
      s_d = s_q;
      if (sample_en_i)
      begin
         s_d.sync1 = {phase2_i, phase1_i}; // R22
         s_d.sync2 = s_q.sync1; // R22
         s_d.first = s_q.sync2; // R14
         s_d.second = s_q.first; // R14
         if (s_q.fill != FILL_DONE)
            s_d.fill = s_q.fill + 3'h1;
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   // Index is {old p2, old p1, new p2, new p1}; double changes are invalid.
   assign idx = {s_q.second, s_q.first};
   // Steps wait until both stages hold real samples, so a wheel left resting
   // between detents at reset is not taken for an edge against the cleared stages.
   assign primed = (s_q.fill == FILL_DONE); // R22
   assign moved = s_q.second ^ s_q.first;
   always_comb
   begin
      step.up = 1'b0;
      step.down = 1'b0;
      if (sample_en_i && primed)
      begin
         case (idx)
            4'h1, 4'h7, 4'hE, 4'h8: step.up = 1'b1; // R12
            4'h2, 4'hB, 4'hD, 4'h4: step.down = 1'b1; // R13
            default: ; // R15
         endcase
      end
   end

   property p_no_both;
      @(posedge mclk_i) disable iff (!rst_b_i) !(step.up && step.down);
   endproperty
   a_no_both: assert property (p_no_both) else $error("up and down together"); // R15

   property p_one_edge;
      @(posedge mclk_i) disable iff (!rst_b_i)
         (sample_en_i && primed && (moved == 2'h1 || moved == 2'h2))
            |-> (step.up != step.down)
               && (step.up == (s_q.first[1] ^ s_q.first[0] ^ moved[1]));
   endproperty
   a_one_edge: assert property (p_one_edge) else $error("edge gave wrong direction"); // R12 R13

   property p_no_edge;
      @(posedge mclk_i) disable iff (!rst_b_i)
         (moved == 2'h0 || moved == 2'h3) |-> !step.up && !step.down;
   endproperty
   a_no_edge: assert property (p_no_edge) else $error("step on invalid transition"); // R15

   property p_unprimed;
      @(posedge mclk_i) disable iff (!rst_b_i) !primed |-> !step.up && !step.down;
   endproperty
   a_unprimed: assert property (p_unprimed) else $error("step before stages filled"); // R22
endmodule
`default_nettype wire

// ==== logic/pdw_top.sv ====
// Functional notes
// R1: A11..A10 decode into four exclusive 1K area selects.
// R2: Any set bit A15..A12 suppresses every area select.
// R3: 3K panel, 2K fade, 1K and 0K RAM.
// R4: Only address bits 9..0 go to on-board peripherals.
// R5: Peripheral data buffer drives processor bus only on on-board reads.
// R6: Seven drive lines across eight sense lines give seven switch bytes.
// R7: Eighth byte location returns the wheel count.
// R8: Encoder gives two quadrature phases indicating up or down.
// R9: Every edge of either phase is one step.
// R10: Movement shown as 8-bit two's complement value.
// R11: Wheel logic samples at 50 kHz.
// R12: Forward step edge cases per phase relationship.
// R13: Reverse step edge cases per phase relationship.
// R14: Two sample stages form a 4-bit transition index.
// R15: Invalid or unchanged transitions enable neither direction.
// R16: Counter steps by one, up by default, down when enabled.
// R17: Down from zero wraps to all ones; bit 7 is direction.
// R18: Counting stops at magnitude 120 in either direction.
// R19: End of a wheel byte read clears the counter.
// R20: Panel bytes drive data only on reads in 3K area.
// R21: Low address bits pick one of eight drive/select lines.
// R22: Phases are synchronised before edge comparison.
`timescale 1ns/100ps
`default_nettype none
module pdw_top #(
   parameter int unsigned SAMPLE_DIV = pdw_pkg::SAMPLE_DIV
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic [15:0] addr_i,
   input wire logic rd_wr_i,
   input wire logic vma_i,
   input wire logic [7:0] matrix_sense_line_i,
   input wire logic phase1_i,
   input wire logic phase2_i,
   output logic [3:0] area_sel_o,
   output logic [9:0] periph_addr_o,
   output logic [6:0] matrix_drive_select_o,
   output logic wheel_byte_select_o,
   output logic [7:0] data_o,
   output logic data_oe_o
);
   typedef struct packed {
      logic [15:0] div;
      logic sample_en;
      logic [7:0] count;
      logic wheel_rd;
      logic [7:0] data;
      logic data_oe;
   } pdw_top_state_t;
   pdw_top_state_t s_q;
   pdw_top_state_t s_d;
   pdw_step_if step_bus();

   logic on_board;
   logic panel_rd;
   logic [7:0] line_sel;
   logic at_pos_limit;
   logic at_neg_limit;
   logic count_down_enable;
   logic forward_step;
   logic reverse_step;

   function automatic logic [7:0] one_hot8(input logic [2:0] v);
      one_hot8 = 8'h01 << v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Address decoding and data direction.

   assign on_board = vma_i && (addr_i[15:pdw_pkg::UPPER_LSB] == 4'h0); // R2
   always_comb
   begin
      area_sel_o = 4'h0;
      if (on_board)
         area_sel_o = 4'(one_hot8({1'b0, addr_i[11:pdw_pkg::AREA_LSB]})); // R1 R3
   end
   assign periph_addr_o = addr_i[pdw_pkg::OFFSET_BITS-1:0]; // R4
   assign panel_rd = area_sel_o[pdw_pkg::AREA_PANEL] && rd_wr_i; // R20
   assign line_sel = panel_rd ? one_hot8(addr_i[2:0]) : 8'h00; // R21
   assign matrix_drive_select_o = line_sel[pdw_pkg::DRIVE_LINES-1:0]; // R6
   assign wheel_byte_select_o = line_sel[pdw_pkg::WHEEL_INDEX]; // R7

   ////////////////////////////////////////////////////////////////////////////
   // Wheel stepping.

   pdw_quad_decode u_dec (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .sample_en_i(s_q.sample_en),
      .phase1_i(phase1_i),
      .phase2_i(phase2_i),
      .step(step_bus)
   );

   assign forward_step = step_bus.up;
   assign reverse_step = step_bus.down;
   assign count_down_enable = reverse_step; // R16
   assign at_pos_limit = $signed(s_q.count) >= pdw_pkg::COUNT_LIMIT; // R18
   assign at_neg_limit = $signed(s_q.count) <= -pdw_pkg::COUNT_LIMIT; // R18

   always_comb
   begin
      s_d = s_q;
      s_d.sample_en = 1'b0;
      if (s_q.div == 16'(SAMPLE_DIV - 1))
      begin
         s_d.div = 16'h0000;
         s_d.sample_en = 1'b1; // R11
      end
      else
         s_d.div = s_q.div + 16'h0001;
      s_d.wheel_rd = wheel_byte_select_o;
      // Clearing on the falling select means a step arriving in that cycle is
      // dropped; at 50 kHz sampling this loses at most one edge per read.
      if (s_q.wheel_rd && !wheel_byte_select_o)
         s_d.count = 8'h00; // R19
      else if (count_down_enable && !at_neg_limit)
         s_d.count = s_q.count - 8'h01; // R16 R17 R9
      else if (forward_step && !at_pos_limit)
         s_d.count = s_q.count + 8'h01; // R16 R9 R10
      s_d.data_oe = panel_rd; // R5 R20
      if (wheel_byte_select_o)
         s_d.data = s_q.count; // R7 R10
      else if (panel_rd)
         s_d.data = matrix_sense_line_i; // R6
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign data_o = s_q.data;
   assign data_oe_o = s_q.data_oe;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   // The panel read window is decoded again here from the raw address, so a
   // slip in the select path cannot hide behind its own expression.
   function automatic logic is_panel_read(input logic [15:0] a, input logic rw, input logic v);
      return v && rw && (a[15:pdw_pkg::AREA_LSB] == {4'h0, pdw_pkg::AREA_PANEL});
   endfunction

   property p_upper_block;
      @(posedge mclk_i) disable iff (!rst_b_i) (addr_i[15:12] != 4'h0) |-> area_sel_o == 4'h0;
   endproperty
   a_upper_block: assert property (p_upper_block) else $error("select above 4K"); // R2

   property p_onehot;
      @(posedge mclk_i) disable iff (!rst_b_i) on_board |-> $onehot(area_sel_o);
   endproperty
   a_onehot: assert property (p_onehot) else $error("area select not one-hot"); // R1

   property p_area_code;
      @(posedge mclk_i) disable iff (!rst_b_i) on_board |-> area_sel_o[addr_i[11:10]];
   endproperty
   a_area_code: assert property (p_area_code) else $error("wrong area"); // R3

   property p_oe_read;
      @(posedge mclk_i) disable iff (!rst_b_i) data_oe_o |-> $past(panel_rd);
   endproperty
   a_oe_read: assert property (p_oe_read) else $error("drive outside panel read"); // R5

   property p_limit;
      @(posedge mclk_i) disable iff (!rst_b_i)
         $signed(s_q.count) <= 8'sd120 && $signed(s_q.count) >= -8'sd120;
   endproperty
   a_limit: assert property (p_limit) else $error("count beyond 120"); // R18

   property p_clear;
      @(posedge mclk_i) disable iff (!rst_b_i)
         $fell(wheel_byte_select_o) |=> s_q.count == 8'h00;
   endproperty
   a_clear: assert property (p_clear) else $error("count not cleared"); // R19

   property p_wrap;
      @(posedge mclk_i) disable iff (!rst_b_i)
         (s_q.count == 8'h00 && reverse_step && !s_q.wheel_rd) |=> s_q.count == 8'hFF;
   endproperty
   a_wrap: assert property (p_wrap) else $error("no wrap to all ones"); // R17

   property p_forward;
      @(posedge mclk_i) disable iff (!rst_b_i)
         (forward_step && !at_pos_limit && !s_q.wheel_rd)
            |=> s_q.count == $past(s_q.count) + 8'h01;
   endproperty
   a_forward: assert property (p_forward) else $error("forward step missed"); // R16

   property p_sample_rate;
      @(posedge mclk_i) disable iff (!rst_b_i) s_q.sample_en |=> !s_q.sample_en [*3];
   endproperty
   a_sample_rate: assert property (p_sample_rate) else $error("sample enable too fast"); // R11

   property p_wheel_data;
      @(posedge mclk_i) disable iff (!rst_b_i)
         wheel_byte_select_o |=> data_o == $past(s_q.count);
   endproperty
   a_wheel_data: assert property (p_wheel_data) else $error("wheel byte wrong"); // R7

   property p_select_scope;
      @(posedge mclk_i) disable iff (!rst_b_i)
         (matrix_drive_select_o != 7'h00 || wheel_byte_select_o)
            |-> is_panel_read(addr_i, rd_wr_i, vma_i);
   endproperty
   a_select_scope: assert property (p_select_scope) else $error("panel line outside read"); // R20

   property p_line_onehot;
      @(posedge mclk_i) disable iff (!rst_b_i)
         is_panel_read(addr_i, rd_wr_i, vma_i)
            |-> $onehot({wheel_byte_select_o, matrix_drive_select_o});
   endproperty
   a_line_onehot: assert property (p_line_onehot) else $error("drive lines not one-hot"); // R21

   property p_drive_index;
      @(posedge mclk_i) disable iff (!rst_b_i)
         (is_panel_read(addr_i, rd_wr_i, vma_i) && addr_i[2:0] != pdw_pkg::WHEEL_INDEX)
            |-> matrix_drive_select_o[addr_i[2:0]];
   endproperty
   a_drive_index: assert property (p_drive_index) else $error("wrong drive line"); // R6

   property p_wheel_index;
      @(posedge mclk_i) disable iff (!rst_b_i)
         (is_panel_read(addr_i, rd_wr_i, vma_i) && addr_i[2:0] == pdw_pkg::WHEEL_INDEX)
            |-> wheel_byte_select_o;
   endproperty
   a_wheel_index: assert property (p_wheel_index) else $error("wheel byte not selected"); // R7

   property p_switch_data;
      @(posedge mclk_i) disable iff (!rst_b_i)
         (matrix_drive_select_o != 7'h00)
            |=> data_o == $past(matrix_sense_line_i);
   endproperty
   a_switch_data: assert property (p_switch_data) else $error("switch byte wrong"); // R6

   property p_oe_follow;
      @(posedge mclk_i) disable iff (!rst_b_i)
         is_panel_read(addr_i, rd_wr_i, vma_i) |=> data_oe_o;
   endproperty
   a_oe_follow: assert property (p_oe_follow) else $error("no drive after panel read"); // R5

   property p_write_quiet;
      @(posedge mclk_i) disable iff (!rst_b_i) !rd_wr_i |=> !data_oe_o;
   endproperty
   a_write_quiet: assert property (p_write_quiet) else $error("drive after a write"); // R5

   property p_vma_gate;
      @(posedge mclk_i) disable iff (!rst_b_i)
         !vma_i |-> (area_sel_o == 4'h0) && (matrix_drive_select_o == 7'h00)
            && !wheel_byte_select_o;
   endproperty
   a_vma_gate: assert property (p_vma_gate) else $error("select without valid address"); // R1

   property p_reverse;
      @(posedge mclk_i) disable iff (!rst_b_i)
         (reverse_step && s_q.count != 8'h88 && !s_q.wheel_rd)
            |=> s_q.count == $past(s_q.count) - 8'h01;
   endproperty
   a_reverse: assert property (p_reverse) else $error("reverse step missed"); // R16

   property p_pos_hold;
      @(posedge mclk_i) disable iff (!rst_b_i)
         (forward_step && s_q.count == 8'h78 && !s_q.wheel_rd) |=> s_q.count == 8'h78;
   endproperty
   a_pos_hold: assert property (p_pos_hold) else $error("count passed upper limit"); // R18

   property p_neg_hold;
      @(posedge mclk_i) disable iff (!rst_b_i)
         (reverse_step && s_q.count == 8'h88 && !s_q.wheel_rd) |=> s_q.count == 8'h88;
   endproperty
   a_neg_hold: assert property (p_neg_hold) else $error("count passed lower limit"); // R18

   property p_count_hold;
      @(posedge mclk_i) disable iff (!rst_b_i)
         (!forward_step && !reverse_step && !s_q.wheel_rd) |=> $stable(s_q.count);
   endproperty
   a_count_hold: assert property (p_count_hold) else $error("count moved without a step"); // R16

   property p_step_sampled;
      @(posedge mclk_i) disable iff (!rst_b_i)
         (forward_step || reverse_step) |-> s_q.sample_en;
   endproperty
   a_step_sampled: assert property (p_step_sampled) else $error("step between samples"); // R11

   property p_sign_set;
      @(posedge mclk_i) disable iff (!rst_b_i) $rose(s_q.count[7]) |-> $past(reverse_step);
   endproperty
   a_sign_set: assert property (p_sign_set) else $error("direction bit set going up"); // R17

   property p_sign_clear;
      @(posedge mclk_i) disable iff (!rst_b_i)
         $fell(s_q.count[7])
            |-> $past(forward_step) || ($past(s_q.wheel_rd) && !$past(wheel_byte_select_o));
   endproperty
   a_sign_clear: assert property (p_sign_clear) else $error("direction bit lost"); // R19

   c_wheel_read: cover property (@(posedge mclk_i) $fell(wheel_byte_select_o));
   c_switch_read: cover property (@(posedge mclk_i) matrix_drive_select_o[3]);
   c_limit: cover property (@(posedge mclk_i) at_pos_limit);
   c_neg_limit: cover property (@(posedge mclk_i) at_neg_limit);
   c_reverse: cover property (@(posedge mclk_i) reverse_step);
endmodule
`default_nettype wire

// ==== sim/pdw_panel_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module pdw_panel_model (
   input wire logic mclk_i,
   input wire logic [6:0] drive_i,
   output logic [7:0] sense_o,
   output logic phase1_o,
   output logic phase2_o
);
   logic [7:0] last_q = 8'h00;
   logic [1:0] pos = 2'h0;
   // Each row has its own pattern, so a wrong drive line shows up at once.
   function automatic logic [7:0] row_pattern(input int r);
      return 8'h3C ^ 8'(r * 29);
   endfunction
   // An undriven matrix floats; showing the inverse keeps stale data from passing.
   always_comb
   begin
      sense_o = ~last_q;
      for (int r = 0; r < 7; r++)
         if (drive_i[r])
            sense_o = row_pattern(r);
   end
   always @(posedge mclk_i)
      last_q <= sense_o;
   assign phase1_o = pos[1] ^ pos[0];
   assign phase2_o = pos[1];
   task automatic step(input logic up);
      @(negedge mclk_i);
      pos = up ? pos + 2'h1 : pos - 2'h1;
   endtask
endmodule
`default_nettype wire

// ==== sim/panel_decode_wheel_counter_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module panel_decode_wheel_counter_tb_top;
   logic mclk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic rd_wr = 1'b0;
   logic vma = 1'b0;
   logic [7:0] sense;
   logic ph1;
   logic ph2;
   logic [3:0] area_sel;
   logic [9:0] paddr;
   logic [6:0] drv;
   logic wsel;
   logic [7:0] data;
   logic oe;
   logic [6:0] rsel;
   logic [3:0] rarea;
   logic [9:0] rpaddr;
   logic rwsel;
   logic [7:0] rdat;
   logic roe;
   int n_fail = 0;
   int tests_run = 0;
   int cyc = 0;
   always #2.5 mclk_i = ~mclk_i;
   pdw_top #(.SAMPLE_DIV(8)) dut (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .addr_i(addr),
      .rd_wr_i(rd_wr),
      .vma_i(vma),
      .matrix_sense_line_i(sense),
      .phase1_i(ph1),
      .phase2_i(ph2),
      .area_sel_o(area_sel),
      .periph_addr_o(paddr),
      .matrix_drive_select_o(drv),
      .wheel_byte_select_o(wsel),
      .data_o(data),
      .data_oe_o(oe)
   );
   pdw_panel_model model (
      .mclk_i(mclk_i),
      .drive_i(drv),
      .sense_o(sense),
      .phase1_o(ph1),
      .phase2_o(ph2)
   );
   ////////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Read data is registered, so it is taken one cycle after the select.
   task automatic rd(input logic [15:0] a, input logic wr);
      addr = a;
      rd_wr = ~wr;
      vma = 1'b1;
      @(negedge mclk_i);
      rsel = drv;
      rwsel = wsel;
      rarea = area_sel;
      rpaddr = paddr;
      rdat = data;
      roe = oe;
      vma = 1'b0;
      rd_wr = 1'b0;
      repeat (2) @(negedge mclk_i);
   endtask
   task automatic t_decode();
      logic [15:0] t [7] = '{16'h0000, 16'h07FF, 16'h0BFE, 16'h0C03, 16'h1C00, 16'h4400, 16'h8FFF};
      foreach (t[i])
      begin
         rd(t[i], 1'b1);
         chk("area", t[i][15:12] != 4'h0 ? 16'h0 : 16'h1 << t[i][11:10], {12'h0, rarea});
         chk("paddr", {6'h0, t[i][9:0]}, {6'h0, rpaddr});
         chk("write oe", 16'h0, {15'h0, roe});
      end
      chk("idle area", 16'h0, {12'h0, area_sel});
      rd(16'h0800, 1'b0);
      chk("fade oe", 16'h0, {15'h0, roe});
      rd(16'h1C00, 1'b0);
      chk("high oe", 16'h0, {15'h0, roe});
   endtask
   task automatic t_switch();
      for (int r = 0; r < 8; r++)
      begin
         rd(16'h0C00 | 16'(r), 1'b0);
         chk("drive", r < 7 ? 16'h1 << r : 16'h0, {9'h0, rsel});
         chk("wheel sel", r == 7 ? 16'h1 : 16'h0, {15'h0, rwsel});
         chk("read oe", 16'h1, {15'h0, roe});
         if (r < 7)
            chk("switch", {8'h0, model.row_pattern(r)}, {8'h0, rdat});
         else
            chk("wheel idle", 16'h0, {8'h0, rdat});
      end
   endtask
   // The wheel is left between detents, so a reset must not see the standing
   // phase levels as an edge, and the count must come back cleared.
   task automatic t_reset();
      repeat (3)
      begin
         model.step(1'b1);
         repeat (40) @(negedge mclk_i);
      end
      rst_b_i = 1'b0;
      repeat (4) @(negedge mclk_i);
      chk("reset oe", 16'h0, {15'h0, oe});
      rst_b_i = 1'b1;
      repeat (64) @(negedge mclk_i);
      rd(16'h0C07, 1'b0);
      chk("reset wheel", 16'h0, {8'h0, rdat});
   endtask
   // Each step is given five sample periods to reach the count.
   task automatic t_wheel(input logic up, input int n, input logic [7:0] exp);
      repeat (n)
      begin
         model.step(up);
         repeat (40) @(negedge mclk_i);
      end
      rd(16'h0C07, 1'b0);
      chk("wheel", {8'h0, exp}, {8'h0, rdat});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge mclk_i)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         n_fail++;
         print_verdict();
      end
   end
   initial
   begin
      repeat (4) @(negedge mclk_i);
      rst_b_i = 1'b1;
      @(negedge mclk_i);
      t_decode();
      t_switch();
      t_wheel(1'b1, 5, 8'h05);
      t_wheel(1'b1, 0, 8'h00);
      t_wheel(1'b0, 3, 8'hFD);
      t_wheel(1'b1, 130, 8'h78);
      t_wheel(1'b0, 130, 8'h88);
      t_reset();
      t_wheel(1'b1, 1, 8'h01);
      print_verdict();
   end
endmodule
`default_nettype wire
